// ---- core/cap_port.sv ----
// Tile-side accelerator port: dispatch, response return, memory routing
`timescale 1ns/1ps
`include "cap_map.svh"
module cap_port (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [`CAP_HART_W-1:0] hardware_thread_id,
  input wire logic [`CAP_NUM_ACCEL*`CAP_HART_W-1:0] per_hart_accel_map,
  input wire logic [`CAP_NUM_ACCEL*`CAP_NUM_SLOTS-1:0] accel_slot_set,
  input wire logic core_valid,
  input wire logic [31:0] core_inst,
  input wire logic [`CAP_XLEN-1:0] core_rs1_val,
  input wire logic [`CAP_XLEN-1:0] core_rs2_val,
  output logic core_ready,
  output logic core_illegal,
  output logic resp_valid,
  output logic [`CAP_REG_W-1:0] resp_rd,
  output logic [`CAP_XLEN-1:0] resp_data,
  input wire logic resp_ready,
  output logic [`CAP_NUM_ACCEL-1:0] accel_present,
  output logic [`CAP_NUM_ACCEL-1:0] cmd_valid,
  output logic [`CAP_FUNCT_W-1:0] cmd_funct,
  output logic [`CAP_REG_W-1:0] cmd_rd,
  output logic [`CAP_REG_W-1:0] cmd_rs1,
  output logic [`CAP_REG_W-1:0] cmd_rs2,
  output logic cmd_dest_used_flag,
  output logic cmd_src_a_used_flag,
  output logic cmd_src_b_used_flag,
  output logic [1:0] cmd_coproc_opcode_slot,
  output logic [`CAP_XLEN-1:0] cmd_rs1_val,
  output logic [`CAP_XLEN-1:0] cmd_rs2_val,
  input wire logic [`CAP_NUM_ACCEL-1:0] cmd_ready,
  input wire logic [`CAP_NUM_ACCEL-1:0] acc_resp_valid,
  input wire logic [`CAP_NUM_ACCEL*`CAP_REG_W-1:0] acc_resp_rd,
  input wire logic [`CAP_NUM_ACCEL*`CAP_XLEN-1:0] acc_resp_data,
  output logic [`CAP_NUM_ACCEL-1:0] acc_resp_ready,
  input wire logic [`CAP_NUM_ACCEL-1:0] acc_busy,
  input wire logic [`CAP_NUM_ACCEL-1:0] acc_interrupt,
  output logic core_busy,
  output logic core_interrupt,
  input wire logic [`CAP_NUM_ACCEL-1:0] mem_req_valid,
  output logic [`CAP_NUM_ACCEL-1:0] mem_req_grant,
  input wire logic [`CAP_NUM_ACCEL-1:0] ptw_req_valid,
  output logic [`CAP_NUM_ACCEL-1:0] ptw_req_grant,
  input wire logic [`CAP_NUM_ACCEL-1:0] tile_arbitrated_master_node_req,
  input wire logic icache_refill_req,
  output logic [`CAP_NUM_ACCEL-1:0] tile_arbitrated_master_node_grant,
  output logic icache_refill_grant,
  input wire logic [`CAP_NUM_ACCEL-1:0] crossbar_master_node_req,
  output logic [`CAP_NUM_ACCEL-1:0] crossbar_master_node_grant
);
  localparam int NA = `CAP_NUM_ACCEL;

  typedef struct packed {
    cap_pkg::cap_state_t state;
    cap_pkg::cap_cmd_t cmd;
    logic [NA-1:0] cmd_valid;
    logic [NA-1:0] present;
    logic [NA-1:0] pend_resp;
    logic core_ready;
    logic core_illegal;
    logic resp_valid;
    logic [`CAP_REG_W-1:0] resp_rd;
    logic [`CAP_XLEN-1:0] resp_data;
    logic [NA-1:0] acc_resp_ready;
    logic core_busy;
    logic core_interrupt;
    logic [NA-1:0] mem_grant;
    logic [NA-1:0] ptw_grant;
    logic [NA-1:0] atl_grant;
    logic icache_grant;
    logic [NA-1:0] xbar_grant;
    logic [1:0] rr_ptr;
  } cap_port_st_t;

  cap_port_st_t st_r;
  cap_port_st_t st_nxt;

  logic is_custom;
  logic [1:0] d_slot;
  logic [`CAP_REG_W-1:0] d_rd;
  logic [`CAP_REG_W-1:0] d_rs1;
  logic [`CAP_REG_W-1:0] d_rs2;
  logic [`CAP_FUNCT_W-1:0] d_funct;
  logic d_xd;
  logic d_xs1;
  logic d_xs2;
  logic [NA-1:0] irq_sync;
  logic [NA-1:0] present_now;
  logic [NA-1:0] slot_hit;

  // Field extraction from the issued instruction
  cap_decode u_decode (
    .inst(core_inst),
    .is_custom(is_custom),
    .slot(d_slot),
    .rd(d_rd),
    .rs1(d_rs1),
    .rs2(d_rs2),
    .funct(d_funct),
    .dest_used_flag(d_xd),
    .src_a_used_flag(d_xs1),
    .src_b_used_flag(d_xs2)
  );

  // Per-accelerator presence, slot match and interrupt synchroniser
  genvar g;
  generate
    for (g = 0; g < NA; g++) begin : g_acc
      assign present_now[g] = (per_hart_accel_map[g*`CAP_HART_W +: `CAP_HART_W] == hardware_thread_id);
      assign slot_hit[g] = st_r.present[g] && accel_slot_set[g*`CAP_NUM_SLOTS + d_slot];
      // Accelerator interrupt may be produced off-tile, so it is filtered
      cap_sync u_irq (
        .clk(clk),
        .arst_n(arst_n),
        .d(acc_interrupt[g]),
        .q(irq_sync[g])
      );
    end
  endgenerate

  // Fixed-priority pick of one target: lowest index that claims the slot
  function automatic logic [NA-1:0] cap_first(input logic [NA-1:0] v);
    logic [NA-1:0] r;
    r = '0;
    for (int i = NA - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = '0;
        r[i] = 1'b1;
      end
    end
    return r;
  endfunction : cap_first

  // Round-robin pick starting after rr_ptr, the last response winner; the grant picks do not move it and can starve
  function automatic logic [NA-1:0] cap_rr(input logic [NA-1:0] v, input logic [1:0] ptr);
    logic [NA-1:0] r;
    logic [1:0] k;
    r = '0;
    for (int i = NA; i >= 1; i--) begin
      k = 2'(ptr + 2'(i));
      if (v[k]) begin
        r = '0;
        r[k] = 1'b1;
      end
    end
    return r;
  endfunction : cap_rr

  // Dispatch FSM, response return and resource arbitration
  always_comb begin
    logic [NA-1:0] tgt;
    logic [NA-1:0] rsel;
    logic [NA-1:0] atl;
    logic [NA-1:0] pset;
    tgt = cap_first(slot_hit);
    rsel = cap_rr(acc_resp_valid & st_r.pend_resp, st_r.rr_ptr);
    // Mask before the pick, so an absent requester never swallows the grant
    atl = cap_rr(tile_arbitrated_master_node_req & st_r.present, st_r.rr_ptr);
    pset = '0;
    st_nxt = st_r;
    st_nxt.present = present_now;
    st_nxt.core_ready = 1'b0;
    st_nxt.core_illegal = 1'b0;
    st_nxt.acc_resp_ready = '0;
    case (st_r.state)
      cap_pkg::CAP_IDLE: begin
        // Capture a command when the core offers one
        if (core_valid) begin
          if (is_custom && (tgt != '0)) begin
            st_nxt.cmd.funct = d_funct;
            st_nxt.cmd.rd = d_rd;
            st_nxt.cmd.rs1 = d_rs1;
            st_nxt.cmd.rs2 = d_rs2;
            st_nxt.cmd.dest_used_flag = d_xd;
            st_nxt.cmd.src_a_used_flag = d_xs1;
            st_nxt.cmd.src_b_used_flag = d_xs2;
            st_nxt.cmd.coproc_opcode_slot = d_slot;
            st_nxt.cmd.rs1_val = core_rs1_val;
            st_nxt.cmd.rs2_val = core_rs2_val;
            st_nxt.cmd_valid = tgt;
            st_nxt.core_ready = 1'b1;
            st_nxt.state = cap_pkg::CAP_HOLD;
          end else begin
            // Not a custom opcode, or no accelerator claims it: refuse as illegal
            st_nxt.core_ready = 1'b1;
            st_nxt.core_illegal = 1'b1;
            st_nxt.state = cap_pkg::CAP_WAIT;
          end
        end
      end
      cap_pkg::CAP_HOLD: begin
        // Command stands until the target takes it
        if ((st_r.cmd_valid & cmd_ready) != '0) begin
          st_nxt.cmd_valid = '0;
          if (st_r.cmd.dest_used_flag) begin
            pset = st_r.cmd_valid;
          end
          st_nxt.state = cap_pkg::CAP_IDLE;
        end
      end
      cap_pkg::CAP_WAIT: begin
        // One-cycle gap so the core drops valid after a refusal
        st_nxt.state = cap_pkg::CAP_IDLE;
      end
      default: begin
        st_nxt.state = cap_pkg::CAP_IDLE;
        st_nxt.cmd_valid = '0;
      end
    endcase

    // Response path: one outstanding word toward the core
    if (st_r.resp_valid && resp_ready) begin
      st_nxt.resp_valid = 1'b0;
    end
    if (!st_r.resp_valid && (st_r.acc_resp_ready == '0) && (rsel != '0)) begin
      for (int i = 0; i < NA; i++) begin
        if (rsel[i]) begin
          st_nxt.resp_rd = acc_resp_rd[i*`CAP_REG_W +: `CAP_REG_W];
          st_nxt.resp_data = acc_resp_data[i*`CAP_XLEN +: `CAP_XLEN];
          st_nxt.rr_ptr = 2'(i);
        end
      end
      st_nxt.resp_valid = 1'b1;
      st_nxt.acc_resp_ready = rsel;
      st_nxt.pend_resp = st_nxt.pend_resp & ~rsel;
    end
    // A new pending bit wins over a same-cycle take of the old one
    st_nxt.pend_resp = st_nxt.pend_resp | pset;

    // Busy while a command stands, a present accelerator works or a result is pending
    st_nxt.core_busy = (st_nxt.state == cap_pkg::CAP_HOLD) || ((acc_busy & st_r.present) != '0)
      || (st_nxt.pend_resp != '0);
    st_nxt.core_interrupt = (irq_sync & st_r.present) != '0;

    // Data cache and walker ports, one grant per cycle each
    st_nxt.mem_grant = cap_rr(mem_req_valid & st_r.present, st_r.rr_ptr);
    st_nxt.ptw_grant = cap_rr(ptw_req_valid & st_r.present, st_r.rr_ptr);
    // Instruction cache refill wins the shared arbiter over accelerators
    st_nxt.icache_grant = icache_refill_req;
    st_nxt.atl_grant = icache_refill_req ? '0 : (atl & st_r.present);
    // Crossbar ports pass straight through, no tile-local arbitration
    st_nxt.xbar_grant = crossbar_master_node_req & st_r.present;
  end

  // State register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register
  assign core_ready = st_r.core_ready;
  assign core_illegal = st_r.core_illegal;
  assign resp_valid = st_r.resp_valid;
  assign resp_rd = st_r.resp_rd;
  assign resp_data = st_r.resp_data;
  assign accel_present = st_r.present;
  assign cmd_valid = st_r.cmd_valid;
  assign cmd_funct = st_r.cmd.funct;
  assign cmd_rd = st_r.cmd.rd;
  assign cmd_rs1 = st_r.cmd.rs1;
  assign cmd_rs2 = st_r.cmd.rs2;
  assign cmd_dest_used_flag = st_r.cmd.dest_used_flag;
  assign cmd_src_a_used_flag = st_r.cmd.src_a_used_flag;
  assign cmd_src_b_used_flag = st_r.cmd.src_b_used_flag;
  assign cmd_coproc_opcode_slot = st_r.cmd.coproc_opcode_slot;
  assign cmd_rs1_val = st_r.cmd.rs1_val;
  assign cmd_rs2_val = st_r.cmd.rs2_val;
  assign acc_resp_ready = st_r.acc_resp_ready;
  assign core_busy = st_r.core_busy;
  assign core_interrupt = st_r.core_interrupt;
  assign mem_req_grant = st_r.mem_grant;
  assign ptw_req_grant = st_r.ptw_grant;
  assign tile_arbitrated_master_node_grant = st_r.atl_grant;
  assign icache_refill_grant = st_r.icache_grant;
  assign crossbar_master_node_grant = st_r.xbar_grant;
endmodule : cap_port

// ---- pkg/cap_map.svh ----
// Constants for the custom-instruction accelerator port
`ifndef CAP_MAP_SVH
`define CAP_MAP_SVH
`define CAP_NUM_SLOTS 4
`define CAP_NUM_ACCEL 4
`define CAP_XLEN 64
`define CAP_FUNCT_W 7
`define CAP_REG_W 5
`define CAP_OPC_CUSTOM0 7'h0B
`define CAP_OPC_CUSTOM1 7'h2B
`define CAP_OPC_CUSTOM2 7'h5B
`define CAP_OPC_CUSTOM3 7'h7B
`define CAP_INST_RD_LSB 7
`define CAP_INST_XS2_BIT 12
`define CAP_INST_XS1_BIT 13
`define CAP_INST_XD_BIT 14
`define CAP_INST_RS1_LSB 15
`define CAP_INST_RS2_LSB 20
`define CAP_INST_FUNCT_LSB 25
`define CAP_HART_W 8
`endif

// ---- pkg/cap_pkg.sv ----
// Types for the custom-instruction accelerator port
`include "cap_map.svh"
package cap_pkg;
  typedef enum logic [1:0] {
    CAP_IDLE = 2'b00,
    CAP_HOLD = 2'b01,
    CAP_WAIT = 2'b11
  } cap_state_t;
  typedef struct packed {
    logic [`CAP_FUNCT_W-1:0] funct;
    logic [`CAP_REG_W-1:0] rs2;
    logic [`CAP_REG_W-1:0] rs1;
    logic [`CAP_REG_W-1:0] rd;
    logic dest_used_flag;
    logic src_a_used_flag;
    logic src_b_used_flag;
    logic [1:0] coproc_opcode_slot;
    logic [`CAP_XLEN-1:0] rs1_val;
    logic [`CAP_XLEN-1:0] rs2_val;
  } cap_cmd_t;
endpackage : cap_pkg

// ---- core/cap_sync.sv ----
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module cap_sync (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic d,
  output logic q
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic q;
  } cap_sync_st_t;
  cap_sync_st_t st_r;
  cap_sync_st_t st_nxt;
  // Output only moves once the second and third stages agree
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    if (st_r.s2 == st_r.s3) begin
      st_nxt.q = st_r.s3;
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign q = st_r.q;
endmodule : cap_sync

// ---- core/cap_decode.sv ----
// Opcode-to-slot decoder and field extraction for custom instructions
`timescale 1ns/1ps
`include "cap_map.svh"
module cap_decode (
  input wire logic [31:0] inst,
  output logic is_custom,
  output logic [1:0] slot,
  output logic [`CAP_REG_W-1:0] rd,
  output logic [`CAP_REG_W-1:0] rs1,
  output logic [`CAP_REG_W-1:0] rs2,
  output logic [`CAP_FUNCT_W-1:0] funct,
  output logic dest_used_flag,
  output logic src_a_used_flag,
  output logic src_b_used_flag
);
  // Opcode selects one of four slots
  always_comb begin
    is_custom = 1'b1;
    slot = 2'h0;
    case (inst[6:0])
      `CAP_OPC_CUSTOM0: slot = 2'h0;
      `CAP_OPC_CUSTOM1: slot = 2'h1;
      `CAP_OPC_CUSTOM2: slot = 2'h2;
      `CAP_OPC_CUSTOM3: slot = 2'h3;
      default: is_custom = 1'b0;
    endcase
  end
  // Register numbers, usage flags and function code
  assign rd = inst[`CAP_INST_RD_LSB +: `CAP_REG_W];
  assign rs1 = inst[`CAP_INST_RS1_LSB +: `CAP_REG_W];
  assign rs2 = inst[`CAP_INST_RS2_LSB +: `CAP_REG_W];
  assign funct = inst[`CAP_INST_FUNCT_LSB +: `CAP_FUNCT_W];
  assign dest_used_flag = inst[`CAP_INST_XD_BIT];
  assign src_a_used_flag = inst[`CAP_INST_XS1_BIT];
  assign src_b_used_flag = inst[`CAP_INST_XS2_BIT];
endmodule : cap_decode

// ---- dv/cap_port_checker.sv ----
// Concurrent checks on the accelerator port, bound to its top module
`timescale 1ns/1ps
module cap_port_checker (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [15:0] accel_slot_set,
  input wire logic [31:0] core_inst,
  input wire logic [63:0] core_rs1_val,
  input wire logic core_ready,
  input wire logic resp_valid,
  input wire logic resp_ready,
  input wire logic [63:0] resp_data,
  input wire logic [3:0] acc_resp_ready,
  input wire logic [3:0] accel_present,
  input wire logic [3:0] cmd_valid,
  input wire logic [3:0] cmd_ready,
  input wire logic [6:0] cmd_funct,
  input wire logic [4:0] cmd_rd,
  input wire logic [63:0] cmd_rs1_val,
  input wire logic [1:0] cmd_coproc_opcode_slot,
  input wire logic [3:0] acc_busy,
  input wire logic core_busy,
  input wire logic [3:0] mem_req_valid,
  input wire logic [3:0] mem_req_grant,
  input wire logic icache_refill_req,
  input wire logic icache_refill_grant,
  input wire logic [3:0] tile_arbitrated_master_node_grant,
  input wire logic [3:0] crossbar_master_node_req,
  input wire logic [3:0] crossbar_master_node_grant
);
  logic [3:0] owner;
  // Accelerators that own the slot of the command now offered
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      owner[i] = accel_slot_set[i*4+int'(cmd_coproc_opcode_slot)];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  property p_ready_pulse; core_ready |=> !core_ready; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("core ready longer than one cycle");
  property p_cmd_hold; |(cmd_valid & ~cmd_ready) |=> $stable(cmd_valid) && $stable(cmd_rs1_val); endproperty
  a_cmd_hold: assert property (p_cmd_hold) else $error("command changed before taken");
  property p_cmd_fields;
    $rose(|cmd_valid) |-> cmd_funct == $past(core_inst[31:25]) && cmd_rd == $past(core_inst[11:7])
      && cmd_rs1_val == $past(core_rs1_val);
  endproperty
  a_cmd_fields: assert property (p_cmd_fields) else $error("command fields differ from instruction");
  property p_target; |cmd_valid |-> $onehot(cmd_valid) && |(cmd_valid & accel_present & owner); endproperty
  a_target: assert property (p_target) else $error("command sent to wrong accelerator");
  property p_resp_hold; resp_valid && !resp_ready |=> resp_valid && $stable(resp_data); endproperty
  a_resp_hold: assert property (p_resp_hold) else $error("response dropped before accepted");
  property p_resp_take; $rose(resp_valid) |-> $onehot(acc_resp_ready); endproperty
  a_resp_take: assert property (p_resp_take) else $error("response not taken from one accelerator");
  property p_xbar; crossbar_master_node_grant == $past(crossbar_master_node_req & accel_present); endproperty
  a_xbar: assert property (p_xbar) else $error("crossbar grant not direct");
  property p_icache;
    icache_refill_req |=> icache_refill_grant && tile_arbitrated_master_node_grant == 4'h0;
  endproperty
  a_icache: assert property (p_icache) else $error("refill path lost shared arbiter");
  property p_mem;
    |mem_req_grant |-> $onehot(mem_req_grant)
      && (mem_req_grant & ~$past(mem_req_valid & accel_present)) == 4'h0;
  endproperty
  a_mem: assert property (p_mem) else $error("cache grant without request");
  property p_busy; |(acc_busy & accel_present) |=> core_busy; endproperty
  a_busy: assert property (p_busy) else $error("busy accelerator not reported");
  c_resp: cover property (resp_valid && resp_ready);
  c_icache: cover property (icache_refill_grant);
  c_stall: cover property (|(cmd_valid & ~cmd_ready));
endmodule : cap_port_checker
bind cap_port cap_port_checker i_chk (.clk, .arst_n, .accel_slot_set, .core_inst, .core_rs1_val, .core_ready,
  .resp_valid, .resp_ready, .resp_data, .acc_resp_ready, .accel_present, .cmd_valid, .cmd_ready, .cmd_funct,
  .cmd_rd, .cmd_rs1_val, .cmd_coproc_opcode_slot, .acc_busy, .core_busy, .mem_req_valid, .mem_req_grant,
  .icache_refill_req, .icache_refill_grant, .tile_arbitrated_master_node_grant, .crossbar_master_node_req,
  .crossbar_master_node_grant);

// ---- dv/cap_acc_model.sv ----
// Behavioural model of the four accelerators behind the port
`timescale 1ns/1ps
module cap_acc_model (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [3:0] cmd_valid,
  input wire logic [4:0] cmd_rd,
  input wire logic cmd_dest_used_flag,
  input wire logic [63:0] cmd_rs1_val,
  input wire logic [63:0] cmd_rs2_val,
  output logic [3:0] cmd_ready,
  output logic [3:0] acc_resp_valid,
  output logic [19:0] acc_resp_rd,
  output logic [255:0] acc_resp_data,
  input wire logic [3:0] acc_resp_ready,
  output logic [3:0] acc_busy
);
  for (genvar i = 0; i < 4; i++) begin : g_acc
    logic [3:0] stall_r;
    logic [1:0] work_r;
    logic pend_r;
    logic rv_r;
    logic [4:0] rd_r;
    logic [63:0] val_r;
    // Accelerator i stalls i cycles, so both prompt and slow takes occur
    assign cmd_ready[i] = cmd_valid[i] && int'(stall_r) >= i;
    assign acc_busy[i] = work_r != 2'h0 || pend_r;
    assign acc_resp_valid[i] = rv_r;
    // Released lines show the inverse so stale data cannot pass
    assign acc_resp_rd[i*5+:5] = rv_r ? rd_r : ~rd_r;
    assign acc_resp_data[i*64+:64] = rv_r ? val_r : ~val_r;
    // Take, work three cycles, then offer one result until taken
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        stall_r <= 4'h0;
        work_r <= 2'h0;
        pend_r <= 1'b0;
        rv_r <= 1'b0;
        rd_r <= 5'h0;
        val_r <= 64'h0;
      end else begin
        stall_r <= (cmd_valid[i] && !cmd_ready[i]) ? stall_r + 4'h1 : 4'h0;
        if (cmd_valid[i] && cmd_ready[i]) begin
          work_r <= 2'h3;
          pend_r <= cmd_dest_used_flag;
          rd_r <= cmd_rd;
          val_r <= cmd_rs1_val + cmd_rs2_val;
        end else if (work_r != 2'h0) begin
          work_r <= work_r - 2'h1;
        end
        if (work_r == 2'h1 && pend_r) begin
          rv_r <= 1'b1;
        end else if (rv_r && acc_resp_ready[i]) begin
          rv_r <= 1'b0;
          pend_r <= 1'b0;
        end
      end
    end
  end
endmodule : cap_acc_model

// ---- dv/testbench.sv ----
// Self-checking bench for the accelerator port
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0, arst_n = 1'b0, core_valid = 1'b0, resp_ready = 1'b0, icache_refill_req = 1'b0;
  logic [31:0] core_inst = 32'h0;
  logic [63:0] core_rs1_val = 64'h0, core_rs2_val = 64'h0;
  logic [3:0] acc_interrupt = 4'h0, mem_req_valid = 4'h0, ptw_req_valid = 4'h0;
  logic [3:0] tile_arbitrated_master_node_req = 4'h0, crossbar_master_node_req = 4'h0;
  logic core_ready, core_illegal, resp_valid, core_busy, core_interrupt, icache_refill_grant;
  logic cmd_dest_used_flag, cmd_src_a_used_flag, cmd_src_b_used_flag;
  logic [1:0] cmd_coproc_opcode_slot;
  logic [4:0] resp_rd, cmd_rd, cmd_rs1, cmd_rs2;
  logic [6:0] cmd_funct;
  logic [63:0] resp_data, cmd_rs1_val, cmd_rs2_val;
  logic [3:0] accel_present, cmd_valid, cmd_ready, acc_resp_valid, acc_resp_ready, acc_busy;
  logic [3:0] mem_req_grant, ptw_req_grant, tile_arbitrated_master_node_grant, crossbar_master_node_grant;
  logic [19:0] acc_resp_rd;
  logic [255:0] acc_resp_data;
  int num_errors = 0, samples_checked = 0;
  // Tile 3: accelerators 0..2 present, accelerator 3 belongs to another tile
  cap_port i_dut (.clk, .arst_n, .hardware_thread_id(8'h03), .per_hart_accel_map(32'h05030303),
    .accel_slot_set(16'h8065), .core_valid, .core_inst, .core_rs1_val, .core_rs2_val, .core_ready, .core_illegal,
    .resp_valid, .resp_rd, .resp_data, .resp_ready, .accel_present, .cmd_valid, .cmd_funct, .cmd_rd, .cmd_rs1,
    .cmd_rs2, .cmd_dest_used_flag, .cmd_src_a_used_flag, .cmd_src_b_used_flag, .cmd_coproc_opcode_slot,
    .cmd_rs1_val, .cmd_rs2_val, .cmd_ready, .acc_resp_valid, .acc_resp_rd, .acc_resp_data, .acc_resp_ready,
    .acc_busy, .acc_interrupt, .core_busy, .core_interrupt, .mem_req_valid, .mem_req_grant, .ptw_req_valid,
    .ptw_req_grant, .tile_arbitrated_master_node_req, .icache_refill_req, .tile_arbitrated_master_node_grant,
    .icache_refill_grant, .crossbar_master_node_req, .crossbar_master_node_grant);
  cap_acc_model i_acc (.clk, .arst_n, .cmd_valid, .cmd_rd, .cmd_dest_used_flag, .cmd_rs1_val, .cmd_rs2_val,
    .cmd_ready, .acc_resp_valid, .acc_resp_rd, .acc_resp_data, .acc_resp_ready, .acc_busy);
  // 200 MHz clock
  always #2.5 clk = ~clk;
  task automatic chk(input string name, input logic [127:0] exp, input logic [127:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %0h seen %0h", name, exp, got);
    end
  endtask : chk
  // One instruction: offer, check dispatch, then collect the result if one is due
  task automatic issue(input logic [6:0] opc, input logic [6:0] fn, input logic [4:0] rd, input logic [2:0] fl,
      input logic [63:0] v1, input logic [3:0] tgt);
    logic [63:0] v2;
    int n;
    v2 = {v1[31:0], v1[63:32]};
    @(negedge clk);
    core_valid = 1'b1;
    core_inst = {fn, 5'h0C, 5'h03, fl, rd, opc};
    core_rs1_val = v1;
    core_rs2_val = v2;
    n = 0;
    do begin @(negedge clk); n++; end while (core_ready !== 1'b1 && n < 50);
    core_valid = 1'b0;
    chk("core_ready", 1'b1, core_ready);
    chk("illegal", tgt == 4'h0, core_illegal);
    chk("cmd_valid", tgt, cmd_valid);
    if (tgt != 4'h0) begin
      chk("cmd_fields", {fn, rd, 5'h03, 5'h0C, fl, opc[6:5]}, {cmd_funct, cmd_rd, cmd_rs1, cmd_rs2,
        cmd_dest_used_flag, cmd_src_a_used_flag, cmd_src_b_used_flag, cmd_coproc_opcode_slot});
      chk("cmd_vals", {v1, v2}, {cmd_rs1_val, cmd_rs2_val});
      chk("busy", 1'b1, core_busy);
    end
    if (fl[2] && tgt != 4'h0) begin
      n = 0;
      do begin @(negedge clk); n++; end while (resp_valid !== 1'b1 && n < 50);
      @(negedge clk);
      chk("resp", {1'b1, rd, v1 + v2}, {resp_valid, resp_rd, resp_data});
      resp_ready = 1'b1;
      @(negedge clk);
      resp_ready = 1'b0;
    end
    @(negedge clk);
  endtask : issue
  task automatic final_report();
    if (num_errors == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report
  // Main sequence
  initial begin
    repeat (20) @(negedge clk);
    arst_n = 1'b1;
    repeat (2) @(negedge clk);
    chk("present", 4'h7, accel_present);
    issue(7'h0B, 7'h01, 5'h01, 3'b111, 64'h0123456789ABCDEF, 4'h1);
    issue(7'h2B, 7'h7F, 5'h1F, 3'b110, 64'hFFFF0000FFFF0000, 4'h2);
    issue(7'h5B, 7'h00, 5'h00, 3'b011, 64'h1, 4'h1);
    issue(7'h7B, 7'h10, 5'h02, 3'b100, 64'h2, 4'h0);
    issue(7'h33, 7'h10, 5'h02, 3'b100, 64'h2, 4'h0);
    mem_req_valid = 4'hF;
    ptw_req_valid = 4'h9;
    tile_arbitrated_master_node_req = 4'h3;
    icache_refill_req = 1'b1;
    crossbar_master_node_req = 4'hA;
    @(negedge clk);
    chk("xbar", 4'h2, crossbar_master_node_grant);
    chk("icache", 5'h10, {icache_refill_grant, tile_arbitrated_master_node_grant});
    chk("mem", 1'b1, $onehot(mem_req_grant) && !mem_req_grant[3]);
    chk("ptw", 4'h1, ptw_req_grant);
    icache_refill_req = 1'b0;
    @(negedge clk);
    chk("arb", 1'b1, $onehot(tile_arbitrated_master_node_grant)
      && tile_arbitrated_master_node_grant[3:2] == 2'h0);
    acc_interrupt = 4'h8;
    repeat (8) @(negedge clk);
    chk("irq_absent", 1'b0, core_interrupt);
    acc_interrupt = 4'h2;
    repeat (8) @(negedge clk);
    chk("irq", 1'b1, core_interrupt);
    acc_interrupt = 4'h0;
    final_report();
  end
  // Watchdog: the tests need fewer than two hundred cycles, so 4000 means a hang
  initial begin
    #20000;
    num_errors++;
    final_report();
  end
endmodule : testbench
